// >>> design/hbs_defs.svh
// constants for the half-bridge serial control block
`ifndef HBS_DEFS_SVH
`define HBS_DEFS_SVH

`define HBS_WORD_W        16
`define HBS_FRAME_BITS    16
`define HBS_CNT_W         5
`define HBS_TMR_W         16
`define HBS_NUM_DRV       6
`define HBS_NUM_PAIR      3
`define HBS_NUM_SYNC      20

`define HBS_BIT_OVERVOLT_LOCKOUT_EN      15
`define HBS_BIT_UL_SD     14
`define HBS_BIT_OC_SEL    13
`define HBS_BIT_UNUSED_HI 11
`define HBS_BIT_UNUSED_LO 7
`define HBS_BIT_DRV_HI    6
`define HBS_BIT_DRV_LO    1
`define HBS_BIT_SRR       0

`define HBS_CMD_RESET     16'h0000
`define HBS_UNUSED_MASK   16'hF07F

`define HBS_CLK_PERIOD_NS 10
`define HBS_OC_LONG_US    200
`define HBS_OC_SHORT_US   25
`define HBS_UL_DELAY_US   350
`define HBS_FILTER_US     10
`define HBS_US_TO_CYC(us) (((us) * 1000) / `HBS_CLK_PERIOD_NS)

`endif

// >>> design/hbs_delay_timer.sv
// delay timer: limit captured at start, pulse once on expiry
`timescale 1ns/1ps
`include "hbs_defs.svh"

module hbs_delay_timer
   import hbs_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  reset,
   input  wire logic                  run,
   input  wire logic [`HBS_TMR_W-1:0] limit,
   output logic                       done
);
   hbs_timer_t s;
   hbs_timer_t next_s;

   always_comb begin
      next_s      = s;
      next_s.done = 1'b0;
      if (!run) begin
         next_s.busy  = 1'b0;
         next_s.fired = 1'b0;
         next_s.cnt   = '0;
      end else if (!s.busy) begin
         next_s.busy = 1'b1;
         next_s.cnt  = `HBS_TMR_W'(1);
         next_s.lim  = limit;
      end else if (!s.fired) begin
         if (s.cnt >= s.lim) begin
            next_s.done  = 1'b1;
            next_s.fired = 1'b1;
         end else begin
            next_s.cnt = s.cnt + `HBS_TMR_W'(1);
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign done = s.done;
endmodule

// >>> design/hbs_pkg.sv
// types of the half-bridge serial control block
`include "hbs_defs.svh"

package hbs_pkg;

   typedef enum logic {
      HBS_IDLE,
      HBS_ACTIVE
   } hbs_frame_t;

   typedef struct packed {
      hbs_frame_t                   frame;
      logic                         sclk_q;
      logic                         cs_q;
      logic [`HBS_WORD_W-1:0]       shreg;
      logic [`HBS_CNT_W-1:0]        bits;
      logic [`HBS_WORD_W-1:0]       cmd;
      logic [`HBS_NUM_DRV-1:0]      drive;
      logic                         so;
      logic                         so_oe;
      logic [`HBS_NUM_DRV-1:0]      oc_off;
      logic [`HBS_NUM_DRV-1:0]      ul_off;
      logic [`HBS_NUM_PAIR-1:0]     xf_block;
      logic                         pf_hold;
      logic                         oc_seen;
      logic                         ul_seen;
      logic                         f_pf;
      logic                         f_ul;
      logic                         f_oc;
      logic                         f_xf;
      logic                         f_tw;
      logic [`HBS_TMR_W-1:0]        filt;
   } hbs_state_t;

   typedef struct packed {
      logic                         busy;
      logic                         fired;
      logic                         done;
      logic [`HBS_TMR_W-1:0]        cnt;
      logic [`HBS_TMR_W-1:0]        lim;
   } hbs_timer_t;

endpackage

// >>> design/hbs_spi_ctrl.sv
// serial control, diagnostics and output gating of a triple half-bridge
`timescale 1ns/1ps
`include "hbs_defs.svh"

module hbs_spi_ctrl
   import hbs_pkg::*;
#(
   parameter int OC_LONG_CYC  = `HBS_US_TO_CYC(`HBS_OC_LONG_US),
   parameter int OC_SHORT_CYC = `HBS_US_TO_CYC(`HBS_OC_SHORT_US),
   parameter int UL_CYC       = `HBS_US_TO_CYC(`HBS_UL_DELAY_US),
   parameter int FILTER_CYC   = `HBS_US_TO_CYC(`HBS_FILTER_US)
) (
   input  wire logic                     clk,
   input  wire logic                     reset,
   input  wire logic                     sclk,
   input  wire logic                     select_n,
   input  wire logic                     si,
   output logic                          so_out,
   output logic                          so_oe,
   input  wire logic                     en,
   input  wire logic                     vs_overvolt,
   input  wire logic                     vs_undervolt,
   input  wire logic                     vcc_undervolt,
   input  wire logic [`HBS_NUM_DRV-1:0]  overcurrent,
   input  wire logic [`HBS_NUM_DRV-1:0]  underload,
   input  wire logic                     thermal_warn,
   output logic [`HBS_NUM_DRV-1:0]       drive_on
);
   localparam int TMR_MAX = (1 << `HBS_TMR_W) - 1;
   localparam logic [`HBS_CNT_W-1:0] FRAME_MIN = `HBS_CNT_W'(`HBS_FRAME_BITS);

   generate
      if (OC_LONG_CYC < 1 || OC_LONG_CYC > TMR_MAX || OC_SHORT_CYC < 1 ||
          OC_SHORT_CYC > TMR_MAX || UL_CYC < 1 || UL_CYC > TMR_MAX ||
          FILTER_CYC < 1 || FILTER_CYC > TMR_MAX) begin : g_bad
         $error("hbs_spi_ctrl: delay counts out of timer range");
      end
   endgenerate

   hbs_state_t s;
   hbs_state_t next_s;

   logic [`HBS_NUM_SYNC-1:0] sy;
   logic                     sy_sclk;
   logic                     sy_cs_n;
   logic                     sy_si;
   logic                     sy_en;
   logic                     sy_ov;
   logic                     sy_uv;
   logic                     sy_vcc_uv;
   logic [`HBS_NUM_DRV-1:0]  sy_oc;
   logic [`HBS_NUM_DRV-1:0]  sy_ul;
   logic                     sy_tw;
   logic                     oc_done;
   logic                     ul_done;
   logic [`HBS_TMR_W-1:0]    oc_limit;
   logic                     sclk_rise;
   logic                     cs_fall;
   logic                     frame_ok;
   logic                     status_clear_req;
   logic [`HBS_WORD_W-1:0]   status;
   logic [`HBS_NUM_DRV-1:0]  pair_block;
   logic                     kill;

   hbs_sync #(
      .W    (`HBS_NUM_SYNC),
      .INIT (`HBS_NUM_SYNC'h40000)
   ) u_sync (
      .clk   (clk),
      .reset (reset),
      .d     ({sclk, select_n, si, en, vs_overvolt, vs_undervolt, vcc_undervolt,
               overcurrent, underload, thermal_warn}),
      .q     (sy)
   );

   assign {sy_sclk, sy_cs_n, sy_si, sy_en, sy_ov, sy_uv, sy_vcc_uv,
           sy_oc, sy_ul, sy_tw} = sy;

   // delay is captured at timer start, so a later bit 13 change cannot cut it
   assign oc_limit = s.cmd[`HBS_BIT_OC_SEL] ? `HBS_TMR_W'(OC_SHORT_CYC)
                                            : `HBS_TMR_W'(OC_LONG_CYC);

   hbs_delay_timer u_oc_tmr (
      .clk   (clk),
      .reset (reset),
      .run   (|(sy_oc & s.drive)),
      .limit (oc_limit),
      .done  (oc_done)
   );

   hbs_delay_timer u_ul_tmr (
      .clk   (clk),
      .reset (reset),
      .run   (|(sy_ul & s.drive)),
      .limit (`HBS_TMR_W'(UL_CYC)),
      .done  (ul_done)
   );

   // status word as it is loaded into the shifter on select_n fall
   assign status = {s.f_pf, s.f_ul, s.f_oc, s.f_xf,
                    5'h00, s.drive, s.f_tw};

   always_comb begin
      next_s    = s;
      sclk_rise = sy_sclk & ~s.sclk_q;
      cs_fall   = ~sy_cs_n & s.cs_q;
      frame_ok  = 1'b0;
      status_clear_req       = 1'b0;
      pair_block = '0;
      next_s.sclk_q = sy_sclk;
      next_s.cs_q   = sy_cs_n;

      case (s.frame)
         HBS_IDLE: begin
            if (cs_fall && sy_en) begin
               next_s.frame = HBS_ACTIVE;
               next_s.bits  = '0;
               next_s.shreg = status;
               next_s.so_oe = 1'b1;
            end
         end
         HBS_ACTIVE: begin
            if (sclk_rise) begin
               next_s.shreg = {sy_si, s.shreg[`HBS_WORD_W-1:1]};
               if (s.bits != FRAME_MIN) begin
                  next_s.bits = s.bits + `HBS_CNT_W'(1);
               end
            end
            if (sy_cs_n || !sy_en) begin
               next_s.frame = HBS_IDLE;
               next_s.so_oe = 1'b0;
               frame_ok     = sy_cs_n && sy_en && (s.bits == FRAME_MIN);
            end
         end
         default: begin
            next_s.frame = HBS_IDLE;
            next_s.so_oe = 1'b0;
         end
      endcase
      next_s.so = next_s.shreg[0];

      if (frame_ok) begin
         next_s.cmd = s.shreg & `HBS_UNUSED_MASK;
         status_clear_req        = s.shreg[`HBS_BIT_SRR];
      end

      // latched conditions: a status clear frame releases, a new event wins
      if (status_clear_req) begin
         next_s.oc_off   = '0;
         next_s.ul_off   = '0;
         next_s.xf_block = '0;
         next_s.pf_hold  = 1'b0;
         next_s.oc_seen  = 1'b0;
         next_s.ul_seen  = 1'b0;
      end
      if (oc_done) begin
         next_s.oc_off  = next_s.oc_off | (sy_oc & s.drive);
         next_s.oc_seen = 1'b1;
      end
      if (ul_done) begin
         next_s.ul_seen = 1'b1;
         if (s.cmd[`HBS_BIT_UL_SD]) begin
            next_s.ul_off = next_s.ul_off | (sy_ul & s.drive);
         end
      end
      if (sy_ov || sy_uv) begin
         next_s.pf_hold = 1'b1;
      end
      for (int i = 0; i < `HBS_NUM_PAIR; i++) begin
         if (frame_ok && s.shreg[2*i+1] && s.shreg[2*i+2]) begin
            next_s.xf_block[i] = 1'b1;
         end
         pair_block[2*i]   = s.xf_block[i];
         pair_block[2*i+1] = s.xf_block[i];
      end

      // fault flags: cleared by a valid frame, re-latched after the filter
      if (frame_ok) begin
         next_s.filt = `HBS_TMR_W'(FILTER_CYC);
         next_s.f_pf = 1'b0;
         next_s.f_ul = 1'b0;
         next_s.f_oc = 1'b0;
         next_s.f_xf = 1'b0;
         next_s.f_tw = 1'b0;
      end else if (s.filt != '0) begin
         next_s.filt = s.filt - `HBS_TMR_W'(1);
      end else begin
         next_s.f_pf = s.f_pf | s.pf_hold | sy_ov | sy_uv;
         next_s.f_ul = s.f_ul | s.ul_seen;
         next_s.f_oc = s.f_oc | s.oc_seen;
         next_s.f_xf = s.f_xf | (|s.xf_block);
         next_s.f_tw = s.f_tw | sy_tw;
      end

      // output gating; the command word itself is never touched here
      kill = !sy_en || sy_vcc_uv || sy_uv ||
             (s.cmd[`HBS_BIT_OVERVOLT_LOCKOUT_EN] && sy_ov);
      if (kill) begin
         next_s.drive = '0;
      end else begin
         next_s.drive = s.cmd[`HBS_BIT_DRV_HI:`HBS_BIT_DRV_LO]
                        & ~s.oc_off & ~s.ul_off & ~pair_block;
      end
   end

   // power stage supply enters through the gating term above and through pf_hold and f_pf
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s        <= '0;
         s.frame  <= HBS_IDLE;
         s.cs_q   <= 1'b1;
         s.cmd    <= `HBS_CMD_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign so_out   = s.so;
   assign so_oe    = s.so_oe;
   assign drive_on = s.drive;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence seq_frame_end;
      s.frame == HBS_ACTIVE ##1 s.frame == HBS_IDLE;
   endsequence

   sequence seq_short_end;
      (s.frame == HBS_ACTIVE && s.bits < FRAME_MIN) ##1 s.frame == HBS_IDLE;
   endsequence

   a_so_released: assert property (
      s.frame == HBS_IDLE && $past(s.frame) == HBS_IDLE |-> !so_oe)
      else $error("serial output driven outside a frame");

   a_short_keep: assert property (
      seq_short_end |-> s.cmd == $past(s.cmd))
      else $error("short frame changed the command word");

   a_full_latch: assert property (
      frame_ok |=> s.cmd == ($past(s.shreg) & `HBS_UNUSED_MASK))
      else $error("valid frame did not latch the shifted word");

   a_count_cap: assert property (
      s.frame == HBS_ACTIVE |-> s.bits <= FRAME_MIN)
      else $error("edge counter ran past its cap");

   a_shift_lsb: assert property (
      s.frame == HBS_ACTIVE && sclk_rise && !sy_cs_n && sy_en
      |=> s.shreg[`HBS_WORD_W-1] == $past(sy_si) ##1 so_out == $past(s.shreg[0]))
      else $error("serial shift order wrong");

   a_flag_clear: assert property (
      frame_ok |=> !s.f_pf && !s.f_ul && !s.f_oc && !s.f_xf && !s.f_tw
                   && s.filt == `HBS_TMR_W'(FILTER_CYC))
      else $error("valid frame did not clear the fault flags");

   a_crossfire_off: assert property (
      s.xf_block[0] |=> !drive_on[0] && !drive_on[1])
      else $error("blocked bridge still driven");

   a_lockout_off: assert property (
      s.cmd[`HBS_BIT_OVERVOLT_LOCKOUT_EN] && sy_ov |=> drive_on == '0)
      else $error("drivers on during overvoltage lockout");

   a_sleep_off: assert property (
      !sy_en |=> drive_on == '0 ##0 !so_oe)
      else $error("drivers or output active in sleep");

   a_frame_leaves: assert property (
      seq_frame_end |-> $past(sy_cs_n, 1) || !$past(sy_en, 1))
      else $error("frame closed without select_n high or sleep");

   a_status_load: assert property (
      s.frame == HBS_IDLE && cs_fall && sy_en
      |=> s.shreg == {$past(s.f_pf), $past(s.f_ul), $past(s.f_oc), $past(s.f_xf),
                      5'h00, $past(s.drive), $past(s.f_tw)})
      else $error("status word not loaded at frame start");

   a_unused_zero: assert property (
      s.cmd[`HBS_BIT_UNUSED_HI:`HBS_BIT_UNUSED_LO] == 5'h00)
      else $error("unused command bits latched");

   a_oe_open: assert property (
      s.frame == HBS_IDLE && cs_fall && sy_en |=> so_oe && s.bits == '0)
      else $error("frame start did not enable output or arm counter");

   a_count_step: assert property (
      s.frame == HBS_ACTIVE && sclk_rise && s.bits != FRAME_MIN
      |=> s.bits == $past(s.bits) + `HBS_CNT_W'(1))
      else $error("edge counter missed a serial clock rise");

   a_drive_follow: assert property (
      !kill && s.oc_off == '0 && s.ul_off == '0 && s.xf_block == '0
      |=> drive_on == $past(s.cmd[`HBS_BIT_DRV_HI:`HBS_BIT_DRV_LO]))
      else $error("drivers do not follow the command word");

   a_uv_off: assert property (
      sy_uv || sy_vcc_uv |=> drive_on == '0)
      else $error("drivers on during supply undervoltage");

   a_pf_latch: assert property (
      sy_ov || sy_uv |=> s.pf_hold)
      else $error("supply fault not held");

   a_xf_set: assert property (
      frame_ok && s.shreg[1] && s.shreg[2] |=> s.xf_block[0])
      else $error("crossfire command did not block the bridge");

   a_oc_latch: assert property (
      oc_done && sy_oc[0] && s.drive[0] |=> s.oc_off[0] ##1 !drive_on[0])
      else $error("overcurrent did not latch the driver off");

   a_oc_hold: assert property (
      s.oc_off[0] && !status_clear_req |=> s.oc_off[0])
      else $error("overcurrent latch released without status clear");

   a_ul_shutdown: assert property (
      ul_done && s.cmd[`HBS_BIT_UL_SD] && sy_ul[0] && s.drive[0]
      |=> s.ul_off[0] ##1 !drive_on[0])
      else $error("underload did not latch the driver off");

   a_srr_release: assert property (
      status_clear_req && !oc_done && !ul_done |=> s.oc_off == '0 && s.ul_off == '0)
      else $error("status clear left a latched shutdown");

   a_filter_wait: assert property (
      s.filt != '0 && !frame_ok
      |=> s.f_oc == $past(s.f_oc) && s.f_ul == $past(s.f_ul) && s.f_tw == $past(s.f_tw))
      else $error("fault flags changed inside the filter time");
endmodule

// >>> design/hbs_sync.sv
// two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps

module hbs_sync #(
   parameter int             W    = 1,
   parameter logic [W-1:0]   INIT = '0
) (
   input  wire logic         clk,
   input  wire logic         reset,
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } hbs_sync_t;

   hbs_sync_t s;
   hbs_sync_t next_s;

   always_comb begin
      next_s    = s;
      next_s.s1 = d;
      next_s.s2 = s.s1;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s <= {INIT, INIT};
      end else begin
         s <= next_s;
      end
   end

   assign q = s.s2;
endmodule

// >>> tb/hbs_host_model.sv
// serial host model for the half-bridge control link
`timescale 1ns/1ps

module hbs_host_model (
   output logic      sclk,
   output logic      select_n,
   output logic      si,
   input  wire logic so_out,
   input  wire logic so_oe
);
   logic oe_seen;

   initial begin
      sclk     = 1'b0;
      select_n = 1'b1;
      si       = 1'b0;
      oe_seen  = 1'b1;
   end

   // n bits, lsb first; r holds what came back
   task automatic xfer(input int n, input logic [31:0] d, output logic [31:0] r);
      r = '0;
      oe_seen = 1'b1;
      select_n = 1'b0;
      #200;
      for (int i = 0; i < n; i++) begin
         si = d[i];
         #62.5;
         r[i] = so_oe ? so_out : ~so_out;
         oe_seen = oe_seen & so_oe;
         sclk = 1'b1;
         #62.5;
         sclk = 1'b0;
      end
      #100;
      si = 1'b0;
      select_n = 1'b1;
      #5000;
   endtask
endmodule

// >>> tb/hbs_spi_ctrl_bench.sv
// self-checking bench of the half-bridge serial control block
`timescale 1ns/1ps

module hbs_spi_ctrl_bench;
   import hbs_pkg::*;
   logic        clk;
   logic        reset;
   logic        sclk;
   logic        select_n;
   logic        si;
   logic        so_out;
   logic        so_oe;
   logic        en;
   logic        vs_ov;
   logic        vs_uv;
   logic        vcc_uv;
   logic [5:0]  oc;
   logic [5:0]  ul;
   logic        tw;
   logic [5:0]  drive_on;
   logic [31:0] rx;
   int          n_mismatch;
   int          checks;

   hbs_spi_ctrl #(
      .OC_LONG_CYC  (200),
      .OC_SHORT_CYC (25),
      .UL_CYC       (100),
      .FILTER_CYC   (10)
   ) i_hbs_spi_ctrl (
      .clk           (clk),
      .reset         (reset),
      .sclk          (sclk),
      .select_n      (select_n),
      .si            (si),
      .so_out        (so_out),
      .so_oe         (so_oe),
      .en            (en),
      .vs_overvolt   (vs_ov),
      .vs_undervolt  (vs_uv),
      .vcc_undervolt (vcc_uv),
      .overcurrent   (oc),
      .underload     (ul),
      .thermal_warn  (tw),
      .drive_on      (drive_on)
   );

   hbs_host_model i_hbs_host_model (
      .sclk     (sclk),
      .select_n (select_n),
      .si       (si),
      .so_out   (so_out),
      .so_oe    (so_oe)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   task automatic frame(input int n, input logic [31:0] d);
      @(posedge clk);
      #1;
      i_hbs_host_model.xfer(n, d, rx);
      @(posedge clk);
      #1;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      #500000;
      n_mismatch++;
      test_done();
   end

   initial begin
      n_mismatch = 0;
      checks = 0;
      reset = 1'b1;
      en = 1'b1;
      vs_ov = 1'b0;
      vs_uv = 1'b0;
      vcc_uv = 1'b0;
      oc = 6'h00;
      ul = 6'h00;
      tw = 1'b0;
      rx = '0;
      wait_cyc(8);
      reset = 1'b0;
      wait_cyc(4);
      check(drive_on, 6'h00);
      check(so_oe, 1'b0);
      $display("test reset done");
      frame(16, 32'h0FD4);
      check(rx, 32'h0000);
      check(i_hbs_host_model.oe_seen, 1'b1);
      check(so_oe, 1'b0);
      check(drive_on, 6'h2A);
      frame(15, 32'h0000);
      check(rx, 32'h0054);
      check(drive_on, 6'h2A);
      $display("test frame done");
      tw = 1'b1;
      wait_cyc(30);
      frame(16, 32'h0006);
      check(rx, 32'h0055);
      check(drive_on, 6'h00);
      frame(16, 32'h0002);
      tw = 1'b0;
      check(rx[12], 1'b1);
      check(drive_on, 6'h00);
      frame(16, 32'h0003);
      check(drive_on, 6'h01);
      $display("test crossfire done");
      oc[0] = 1'b1;
      wait_cyc(100);
      check(drive_on, 6'h01);
      oc[0] = 1'b0;
      frame(16, 32'h2002);
      check(rx, 32'h0002);
      oc[0] = 1'b1;
      wait_cyc(60);
      check(drive_on, 6'h00);
      oc[0] = 1'b0;
      frame(16, 32'h2002);
      check(rx, 32'h2000);
      check(drive_on, 6'h00);
      frame(16, 32'h2003);
      check(drive_on, 6'h01);
      $display("test overcurrent done");
      frame(16, 32'h8002);
      vs_ov = 1'b1;
      wait_cyc(20);
      check(drive_on, 6'h00);
      vs_ov = 1'b0;
      wait_cyc(20);
      check(drive_on, 6'h01);
      frame(16, 32'h0003);
      check(rx[15], 1'b1);
      vs_ov = 1'b1;
      wait_cyc(20);
      check(drive_on, 6'h01);
      vs_ov = 1'b0;
      $display("test overvoltage done");
      frame(16, 32'h4002);
      check(rx, 32'h8002);
      ul[0] = 1'b1;
      wait_cyc(120);
      check(drive_on, 6'h00);
      ul[0] = 1'b0;
      frame(16, 32'h4003);
      check(rx, 32'hC000);
      check(drive_on, 6'h01);
      $display("test underload done");
      vs_uv = 1'b1;
      frame(32, {16'h0010, 16'hABCD});
      check(rx[31:16], 16'hABCD);
      check(drive_on, 6'h00);
      vs_uv = 1'b0;
      wait_cyc(20);
      check(drive_on, 6'h08);
      vcc_uv = 1'b1;
      wait_cyc(20);
      check(drive_on, 6'h00);
      vcc_uv = 1'b0;
      wait_cyc(20);
      en = 1'b0;
      wait_cyc(20);
      check(drive_on, 6'h00);
      frame(16, 32'h0004);
      check(i_hbs_host_model.oe_seen, 1'b0);
      en = 1'b1;
      wait_cyc(20);
      check(drive_on, 6'h08);
      $display("test supply done");
      test_done();
   end
endmodule
